// ### logic/eedm_pkg.sv
// Package of constants and carrier types for the data memory access block
package eedm_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] MISC_CTRL_OFFSET   = 8'h96;
    localparam logic [7:0] MISC_CTRL_RESET    = 8'h02;
    localparam int         SPACE_SELECT_BIT   = 3;
    localparam int         WRITE_ALLOW_BIT    = 4;
    localparam int         DONE_FLAG_BIT      = 1;
    localparam logic [7:0] MISC_CTRL_WR_MASK  = 8'hfd;
    // ==========================================================
    // Address spaces
    localparam int         EE_ADDR_W          = 11;
    localparam int         EE_BYTES           = 2048;
    localparam int         RAM_BYTES          = 256;
    localparam logic [7:0] LOWER_RAM_TOP      = 8'h7f;
    // ==========================================================
    // Timing
    localparam int         CLK_HZ             = 100_000_000;
    localparam int         EE_WRITE_US        = 2500;
    localparam int         EE_WRITE_CYCLES    = EE_WRITE_US * (CLK_HZ / 1_000_000);
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xmove_req_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        indirect;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } imem_req_t;

    typedef enum logic [1:0] {
        EE_IDLE  = 2'b01,
        EE_WRITE = 2'b10
    } ee_state_t;
endpackage : eedm_pkg

// ### logic/eeprom_data_memory_access.sv
// Data memory access: EEPROM space, external move routing, internal RAM split
`timescale 1ns/100ps
module eeprom_data_memory_access #(
    parameter int WRITE_CYCLES = eedm_pkg::EE_WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic                CLK_SYS_I,
    input  wire logic                SYS_RST_I,
    // External move request from the core
    input  wire eedm_pkg::xmove_req_t XMOVE_I,
    output logic [7:0]               XMOVE_RDATA_O,
    // Off-chip data memory port
    output logic                     EXT_RD_O,
    output logic                     EXT_WR_O,
    output logic [15:0]              EXT_ADDR_O,
    output logic [7:0]               EXT_WDATA_O,
    input  wire logic [7:0]          EXT_RDATA_I,
    // Internal memory request from the core
    input  wire eedm_pkg::imem_req_t IMEM_I,
    output logic [7:0]               IMEM_RDATA_O,
    // Special function space port
    output logic                     SPEC_RD_O,
    output logic                     SPEC_WR_O,
    output logic [7:0]               SPEC_ADDR_O,
    output logic [7:0]               SPEC_WDATA_O,
    input  wire logic [7:0]          SPEC_RDATA_I,
    // Status
    output logic                     WRITE_DONE_O,
    output logic [7:0]               MISC_CTRL_O
);
    import eedm_pkg::*;

    initial begin
        if (WRITE_CYCLES < 1 || WRITE_CYCLES > 2**24 - 1) begin
            $error("WRITE_CYCLES out of range");
        end
    end

    // ==========================================================
    // Storage
    logic [7:0] ee_mem  [EE_BYTES];
    logic [7:0] ram_mem [RAM_BYTES];

    // ==========================================================
    // Control register and write timer state
    logic [7:0]              misc_r,  misc_nxt;
    ee_state_t               state_r, state_nxt;
    logic [23:0]             cnt_r,   cnt_nxt;
    logic [EE_ADDR_W-1:0]    wa_r,    wa_nxt;
    logic [7:0]              wd_r,    wd_nxt;

    // ==========================================================
    // Decode
    logic ctrl_hit;
    logic ee_sel;
    logic ee_in_range;
    logic ee_wr_go;
    logic ram_dir;
    assign ee_in_range = (XMOVE_I.addr[15:EE_ADDR_W] == '0);
    assign ee_sel      = misc_r[SPACE_SELECT_BIT] && ee_in_range;
    assign ee_wr_go    = ee_sel && XMOVE_I.wr && misc_r[WRITE_ALLOW_BIT] && state_r == EE_IDLE;
    assign ram_dir     = IMEM_I.indirect || IMEM_I.addr <= LOWER_RAM_TOP;
    assign ctrl_hit    = !ram_dir && IMEM_I.addr == MISC_CTRL_OFFSET;

    always_comb begin
        misc_nxt  = misc_r;
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        wa_nxt    = wa_r;
        wd_nxt    = wd_r;
        if (IMEM_I.wr && ctrl_hit) begin
            misc_nxt = (IMEM_I.wdata & MISC_CTRL_WR_MASK) | (misc_r & ~MISC_CTRL_WR_MASK);
        end
        unique case (state_r)
            EE_IDLE: begin
                misc_nxt[DONE_FLAG_BIT] = 1'b1;
                if (ee_wr_go) begin
                    state_nxt               = EE_WRITE;
                    cnt_nxt                 = 24'(WRITE_CYCLES - 1);
                    wa_nxt                  = XMOVE_I.addr[EE_ADDR_W-1:0];
                    wd_nxt                  = XMOVE_I.wdata;
                    misc_nxt[DONE_FLAG_BIT] = 1'b0;
                end
            end
            EE_WRITE: begin
                misc_nxt[DONE_FLAG_BIT] = 1'b0;
                if (cnt_r == '0) begin
                    state_nxt               = EE_IDLE;
                    misc_nxt[DONE_FLAG_BIT] = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 24'h000001;
                end
            end
            default: begin
                state_nxt = EE_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            misc_r  <= MISC_CTRL_RESET;
            state_r <= EE_IDLE;
            cnt_r   <= 24'h000000;
            wa_r    <= '0;
            wd_r    <= 8'h00;
        end else begin
            misc_r  <= misc_nxt;
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            wa_r    <= wa_nxt;
            wd_r    <= wd_nxt;
        end
    end

    // ==========================================================
    // Memory arrays: EEPROM committed on the last timed cycle, RAM in the cycle of the write request
    always_ff @(posedge CLK_SYS_I) begin
        if (state_r == EE_WRITE && cnt_r == '0) begin
            ee_mem[wa_r] <= wd_r;
        end
        if (IMEM_I.wr && ram_dir) begin
            ram_mem[IMEM_I.addr] <= IMEM_I.wdata;
        end
    end

    // ==========================================================
    // Read data and port outputs
    logic [7:0] xrd_nxt;
    logic [7:0] ird_nxt;

    always_comb begin
        xrd_nxt = XMOVE_RDATA_O;
        if (XMOVE_I.rd) begin
            if (!ee_sel) begin
                xrd_nxt = EXT_RDATA_I;
            end else if (state_r == EE_WRITE) begin
                xrd_nxt = {~wd_r[7], wd_r[6:0]};
            end else begin
                xrd_nxt = ee_mem[XMOVE_I.addr[EE_ADDR_W-1:0]];
            end
        end
        ird_nxt = IMEM_RDATA_O;
        if (IMEM_I.rd) begin
            if (ram_dir) begin
                ird_nxt = ram_mem[IMEM_I.addr];
            end else if (ctrl_hit) begin
                ird_nxt = misc_r;
            end else begin
                ird_nxt = SPEC_RDATA_I;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            XMOVE_RDATA_O <= 8'h00;
            IMEM_RDATA_O  <= 8'h00;
            EXT_RD_O      <= 1'b0;
            EXT_WR_O      <= 1'b0;
            EXT_ADDR_O    <= 16'h0000;
            EXT_WDATA_O   <= 8'h00;
            SPEC_RD_O     <= 1'b0;
            SPEC_WR_O     <= 1'b0;
            SPEC_ADDR_O   <= 8'h00;
            SPEC_WDATA_O  <= 8'h00;
            WRITE_DONE_O  <= 1'b1;
            MISC_CTRL_O   <= MISC_CTRL_RESET;
        end else begin
            XMOVE_RDATA_O <= xrd_nxt;
            IMEM_RDATA_O  <= ird_nxt;
            EXT_RD_O      <= XMOVE_I.rd && !ee_sel;
            EXT_WR_O      <= XMOVE_I.wr && !ee_sel;
            EXT_ADDR_O    <= XMOVE_I.addr;
            EXT_WDATA_O   <= XMOVE_I.wdata;
            SPEC_RD_O     <= IMEM_I.rd && !ram_dir && !ctrl_hit;
            SPEC_WR_O     <= IMEM_I.wr && !ram_dir && !ctrl_hit;
            SPEC_ADDR_O   <= IMEM_I.addr;
            SPEC_WDATA_O  <= IMEM_I.wdata;
            WRITE_DONE_O  <= misc_nxt[DONE_FLAG_BIT];
            MISC_CTRL_O   <= misc_nxt;
        end
    end
endmodule : eeprom_data_memory_access

// ### verif/eedm_resp_model.sv
// Off-chip memory and special function space responder
`timescale 1ns/100ps
module eedm_resp_model (
    // Requests seen in their cycle
    input  wire logic        clk_i,
    input  wire logic        ext_rd_i,
    input  wire logic [15:0] ext_addr_i,
    input  wire logic        spec_rd_i,
    input  wire logic [7:0]  spec_addr_i,
    // Read data back to the block
    output logic      [7:0]  ext_rdata_o,
    output logic      [7:0]  spec_rdata_o
);
    logic [7:0] junk_r = 8'h00;
    always_ff @(posedge clk_i) junk_r <= junk_r + 8'h3b;
    // Idle bus shows a moving pattern
    assign ext_rdata_o = ext_rd_i ? (ext_addr_i[7:0] ^ 8'h5a) : junk_r;
    assign spec_rdata_o = spec_rd_i ? (spec_addr_i ^ 8'hc3) : ~junk_r;
endmodule : eedm_resp_model

// ### verif/eeprom_data_memory_access_props.sv
// Checker for routing and write timing
`timescale 1ns/100ps
module eedm_props #(
    parameter int WRITE_CYCLES = eedm_pkg::EE_WRITE_CYCLES
) (
    input wire logic                 CLK_SYS_I,
    input wire logic                 SYS_RST_I,
    input wire eedm_pkg::xmove_req_t XMOVE_I,
    input wire eedm_pkg::imem_req_t  IMEM_I,
    input wire logic                 EXT_RD_O,
    input wire logic                 EXT_WR_O,
    input wire logic [15:0]          EXT_ADDR_O,
    input wire logic [7:0]           EXT_WDATA_O,
    input wire logic                 SPEC_RD_O,
    input wire logic                 SPEC_WR_O,
    input wire logic [7:0]           SPEC_ADDR_O,
    input wire logic [7:0]           SPEC_WDATA_O,
    input wire logic                 WRITE_DONE_O,
    input wire logic [7:0]           MISC_CTRL_O
);
    import eedm_pkg::*;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    logic        ee_hit;
    logic [31:0] busy_r;
    logic [31:0] busy_nxt;
    assign ee_hit = MISC_CTRL_O[3] && (XMOVE_I.addr <= 16'h07ff);
    always_comb busy_nxt = WRITE_DONE_O ? 32'h0 : busy_r + 32'h1;
    always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) busy_r <= 32'h0;
        else busy_r <= busy_nxt;
    end
    sequence s_accept;
        XMOVE_I.wr && ee_hit && MISC_CTRL_O[4] && WRITE_DONE_O;
    endsequence
    sequence s_low;
        !WRITE_DONE_O [*2];
    endsequence
    a_ee_no_ext: assert property (XMOVE_I.wr && ee_hit |=> !EXT_WR_O) else $error("eeprom write leaked");
    a_ext_route: assert property (XMOVE_I.rd && !MISC_CTRL_O[3] |=> EXT_RD_O) else $error("no ext read");
    a_ext_write: assert property (XMOVE_I.wr && !MISC_CTRL_O[3] |=> EXT_WR_O && EXT_ADDR_O == $past(XMOVE_I.addr)
        && EXT_WDATA_O == $past(XMOVE_I.wdata)) else $error("off-chip write lost");
    a_wr_refused: assert property (XMOVE_I.wr && ee_hit && !MISC_CTRL_O[4] && WRITE_DONE_O |=> WRITE_DONE_O)
        else $error("write not refused");
    a_busy_len: assert property ($rose(WRITE_DONE_O) |-> busy_r == WRITE_CYCLES) else $error("busy length");
    a_done_mirror: assert property (WRITE_DONE_O == MISC_CTRL_O[1]) else $error("done flag differs");
    a_done_drop: assert property (s_accept |=> s_low) else $error("done did not drop");
    a_spec_direct: assert property (IMEM_I.rd && !IMEM_I.indirect && IMEM_I.addr > 8'h7f && IMEM_I.addr != 8'h96
        |=> SPEC_RD_O) else $error("no special space read");
    a_spec_write: assert property (IMEM_I.wr && !IMEM_I.indirect && IMEM_I.addr > 8'h7f && IMEM_I.addr != 8'h96
        |=> SPEC_WR_O && SPEC_ADDR_O == $past(IMEM_I.addr) && SPEC_WDATA_O == $past(IMEM_I.wdata))
        else $error("special space write lost");
    a_ram_indirect: assert property ((IMEM_I.rd || IMEM_I.wr) && IMEM_I.indirect |=> !(SPEC_RD_O || SPEC_WR_O))
        else $error("indirect hit special space");
endmodule : eedm_props
bind eeprom_data_memory_access eedm_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.CLK_SYS_I(CLK_SYS_I),
    .SYS_RST_I(SYS_RST_I), .XMOVE_I(XMOVE_I), .IMEM_I(IMEM_I), .EXT_RD_O(EXT_RD_O), .EXT_WR_O(EXT_WR_O),
    .EXT_ADDR_O(EXT_ADDR_O), .EXT_WDATA_O(EXT_WDATA_O), .SPEC_RD_O(SPEC_RD_O), .SPEC_WR_O(SPEC_WR_O),
    .SPEC_ADDR_O(SPEC_ADDR_O), .SPEC_WDATA_O(SPEC_WDATA_O), .WRITE_DONE_O(WRITE_DONE_O),
    .MISC_CTRL_O(MISC_CTRL_O));

// ### verif/tb_eeprom_data_memory_access.sv
// Self-checking bench for the data memory access block
`timescale 1ns/100ps
module tb_eeprom_data_memory_access;
    import eedm_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    xmove_req_t xm = '0;
    imem_req_t  im = '0;
    logic [7:0] x_rd, i_rd, e_dat, s_dat, ctrl;
    logic       done;
    int         err_count = 0;
    int         num_checks = 0;
    eeprom_data_memory_access #(.WRITE_CYCLES(8)) u_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .XMOVE_I(xm),
        .XMOVE_RDATA_O(x_rd), .EXT_RD_O(), .EXT_WR_O(), .EXT_ADDR_O(), .EXT_WDATA_O(), .EXT_RDATA_I(e_dat),
        .IMEM_I(im), .IMEM_RDATA_O(i_rd), .SPEC_RD_O(), .SPEC_WR_O(), .SPEC_ADDR_O(), .SPEC_WDATA_O(),
        .SPEC_RDATA_I(s_dat), .WRITE_DONE_O(done), .MISC_CTRL_O(ctrl));
    eedm_resp_model u_far (.clk_i(clk), .ext_rd_i(xm.rd), .ext_addr_i(xm.addr),
        .spec_rd_i(im.rd && !im.indirect), .spec_addr_i(im.addr), .ext_rdata_o(e_dat), .spec_rdata_o(s_dat));
    initial forever #5 clk = ~clk;
    // ==========================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk
    task automatic xmv(logic r, logic w, logic [15:0] a, logic [7:0] d);
        @(negedge clk) xm = '{r, w, a, d};
        @(negedge clk) xm = '0;
        @(negedge clk);
    endtask : xmv
    task automatic imv(logic r, logic w, logic ind, logic [7:0] a, logic [7:0] d);
        @(negedge clk) im = '{r, w, ind, a, d};
        @(negedge clk) im = '0;
        @(negedge clk);
    endtask : imv
    // ==========================================
    // Scenarios
    task automatic t_offchip();
        chk("ctrl", 8'h02, ctrl);
        xmv(1'b1, 1'b0, 16'h0123, 8'h00);
        chk("ext rd", 8'h79, x_rd);
        xmv(1'b0, 1'b1, 16'h0456, 8'h77);
    endtask : t_offchip
    task automatic t_ee();
        int n;
        imv(1'b0, 1'b1, 1'b0, 8'h96, 8'h18);
        imv(1'b1, 1'b0, 1'b0, 8'h96, 8'h00);
        chk("ctrl", 8'h1a, i_rd);
        xmv(1'b0, 1'b1, 16'h07ff, 8'ha5);
        chk("busy", 8'h00, {7'h0, done});
        xmv(1'b1, 1'b0, 16'h07ff, 8'h00);
        chk("busy rd", 8'h25, x_rd);
        for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge clk);
        if (n == 40) begin
            $display("mismatch done expected 1 seen %b", done);
            err_count++;
            stop_test();
        end
        xmv(1'b1, 1'b0, 16'h07ff, 8'h00);
        chk("ee rd", 8'ha5, x_rd);
        xmv(1'b1, 1'b0, 16'h0800, 8'h00);
        chk("past top", 8'h5a, x_rd);
    endtask : t_ee
    task automatic t_refuse();
        imv(1'b0, 1'b1, 1'b0, 8'h96, 8'h08);
        xmv(1'b0, 1'b1, 16'h07ff, 8'h3c);
        chk("done", 8'h01, {7'h0, done});
        xmv(1'b1, 1'b0, 16'h07ff, 8'h00);
        chk("kept", 8'ha5, x_rd);
    endtask : t_refuse
    task automatic t_ram();
        imv(1'b0, 1'b1, 1'b1, 8'ha0, 8'h11);
        imv(1'b0, 1'b1, 1'b0, 8'ha0, 8'h44);
        imv(1'b1, 1'b0, 1'b0, 8'ha0, 8'h00);
        chk("sfr rd", 8'h63, i_rd);
        imv(1'b1, 1'b0, 1'b1, 8'ha0, 8'h00);
        chk("ram rd", 8'h11, i_rd);
    endtask : t_ram
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_offchip();
        t_ee();
        t_refuse();
        t_ram();
        stop_test();
    end
endmodule : tb_eeprom_data_memory_access
